// ### src/data_space_pkg.sv
// Constants, types and state layout for the data-space and arithmetic decoder.
// Assumes one 40 MHz clock and an APB master for all register access.
package data_space_pkg;
	localparam logic [7:0] BIT_BYTE_MASK = 8'hf8;
	localparam logic [7:0] BIT_RAM_BASE  = 8'h20;
	localparam logic [7:0] SFR_ACC       = 8'he0;
	localparam logic [7:0] SFR_STWORD    = 8'hd0;
	localparam logic [7:0] SFR_SP        = 8'h81;
	localparam logic [7:0] SFR_DPL       = 8'h82;
	localparam logic [7:0] SFR_DPH       = 8'h83;
	localparam logic [7:0] SP_RESET      = 8'h07;
	localparam int         MEM_DEPTH     = 512;

	// APB byte offsets
	localparam logic [7:0] REG_INSTR  = 8'h00;
	localparam logic [7:0] REG_ACC    = 8'h04;
	localparam logic [7:0] REG_STWORD = 8'h08;
	localparam logic [7:0] REG_PC     = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_DADDR  = 8'h14;
	localparam logic [7:0] REG_DATA   = 8'h18;
	localparam logic [7:0] REG_SP     = 8'h1c;
	localparam logic [7:0] REG_DPTR   = 8'h20;
	localparam int         STAT_ILLEGAL = 0;
	localparam int         STAT_LEN_LSB = 2;

	// program_status_word bit positions
	localparam int FLAG_CARRY   = 7;
	localparam int FLAG_AUX     = 6;
	localparam int BANK_SEL_LSB = 3;
	localparam int FLAG_OVER    = 2;
	localparam int FLAG_PARITY  = 0;

	// Opcode groups and operand forms
	localparam logic [3:0] GRP_INC  = 4'h0;
	localparam logic [3:0] GRP_ADD  = 4'h2;
	localparam logic [3:0] GRP_ADD_CARRY  = 4'h3;
	localparam logic [3:0] GRP_SUB_BORROW = 4'h9;
	localparam logic [3:0] LO_IMM   = 4'h4;
	localparam logic [3:0] LO_DIR   = 4'h5;
	localparam logic [2:0] LO_IND   = 3'h3;
	localparam int         LO_REG_BIT = 3;
	localparam logic [7:0] OP_SHORT_JUMP = 8'h80;
	localparam logic [7:0] OP_LONG_JUMP  = 8'h02;
	localparam logic [7:0] OP_LONG_CALL  = 8'h12;
	localparam logic [7:0] OP_MOVDP = 8'h90;
	localparam logic [7:0] OP_SETB  = 8'hd2;
	localparam logic [7:0] OP_CLRB  = 8'hc2;
	localparam logic [4:0] OP_ABS_JUMP = 5'h01;
	localparam logic [4:0] OP_ABS_CALL = 5'h11;
	localparam logic [1:0] LEN1 = 2'd1;
	localparam logic [1:0] LEN2 = 2'd2;
	localparam logic [1:0] LEN3 = 2'd3;

	typedef enum logic [1:0] {ALU_ADD, ALU_ADD_CARRY, ALU_SUB_BORROW, ALU_INC} alu_op_e;
	typedef enum logic [2:0] {ST_IDLE, ST_PTR, ST_OPND, ST_PUSH_LO, ST_PUSH_HI} exec_state_e;

	typedef struct packed {
		logic [7:0] res;
		logic       carry;
		logic       auxCarry;
		logic       overflow;
	} alu_out_s;

	typedef struct packed {
		logic       sfr;
		logic [7:0] addr;
	} data_addr_s;

	typedef struct packed {
		logic       we;
		data_addr_s a;
		logic [7:0] wd;
	} mem_req_s;

	typedef struct packed {
		exec_state_e st;
		logic [23:0] instr;
		logic [7:0]  acc;
		logic [7:0]  statusWord;
		logic [7:0]  sp;
		logic [15:0] pc;
		logic [15:0] dptr;
		logic [15:0] ret;
		data_addr_s  dAddr;
		data_addr_s  opAddr;
		logic        illegal;
		logic [1:0]  len;
		logic        memOnData;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} core_state_s;
endpackage

// ### src/data_ram.sv
// Internal data memory: lower/upper RAM and control register backing store.
// Index is {control space, address}; read data is registered, write-first.
`timescale 1ns/100ps
`default_nettype none
module data_ram (
	input  wire logic                     clk,   // Core clock
	input  wire data_space_pkg::mem_req_s req,   // Access request
	output logic [7:0]                    rdata  // Registered read data
);
	logic [7:0] mem [0:data_space_pkg::MEM_DEPTH-1];

	always_ff @(posedge clk)
	begin
		if (req.we)
		begin
			mem[req.a] <= req.wd;
			rdata <= req.wd;
		end
		else
			rdata <= mem[req.a];
	end
endmodule
`default_nettype wire

// ### src/arith_unit.sv
// Eight-bit adder for add, add_with_carry, subtract_with_borrow and increment.
// Purely combinational; the caller registers the result and flags.
`timescale 1ns/100ps
`default_nettype none
module arith_unit (
	input  wire logic [7:0]              a,    // Left operand
	input  wire logic [7:0]              b,    // Right operand
	input  wire logic                    carryIn, // carry_flag in
	input  wire data_space_pkg::alu_op_e op,   // Operation
	output var  data_space_pkg::alu_out_s y    // Result and flags
);
	logic       sub;
	logic [7:0] bx;
	logic       cx;
	logic [8:0] full;
	logic [4:0] half;

	always_comb
	begin
		sub = op == data_space_pkg::ALU_SUB_BORROW;
		bx = sub ? ~b : (op == data_space_pkg::ALU_INC ? 8'h01 : b);
		cx = op == data_space_pkg::ALU_ADD_CARRY ? carryIn : (sub ? ~carryIn : 1'b0);
		// Subtraction as a + ~b + ~borrow; carries invert into borrows
		full = {1'b0, a} + {1'b0, bx} + {8'h00, cx};
		half = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cx};
		y.res = full[7:0];
		y.carry = full[8] ^ sub;
		y.auxCarry = half[4] ^ sub;
		y.overflow = (a[7] == bx[7]) && (full[7] != a[7]);
	end
endmodule
`default_nettype wire

// ### src/cpu_data_space_arith_decode.sv
// Operand addressing and arithmetic decode with an APB register window.
// Assumes an APB master on clk; instructions arrive as words in the INSTR register.
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module cpu_data_space_arith_decode (
	input  wire logic        clk,     // 40 MHz core clock
	input  wire logic        arst_n,  // Asynchronous reset, active low
	input  wire logic        psel,    // APB select
	input  wire logic        penable, // APB access phase
	input  wire logic        pwrite,  // APB write when high
	input  wire logic [7:0]  paddr,   // APB byte address
	input  wire logic [31:0] pwdata,  // APB write data
	output logic             pready,  // APB ready
	output logic [31:0]      prdata,  // APB read data
	output logic             pslverr, // APB error on unmapped address
	output logic [7:0]       acc,     // Accumulator
	output logic [7:0]       statusWord // program_status_word
);
	import data_space_pkg::*;

	core_state_s q;
	core_state_s d;
	mem_req_s    mreq;
	logic [7:0]  memRd;
	alu_out_s    aluY;
	alu_op_e     aluOp;
	logic [7:0]  aluA;
	logic [7:0]  operand;
	logic [7:0]  opndVal;
	logic [23:0] cur;
	logic [7:0]  opc;
	logic [7:0]  op1;
	logic [3:0]  lo;
	logic [3:0]  hi;
	logic        idle;
	logic        respond;
	logic        start;
	logic        isInc;
	logic        isArith;
	logic        isBit;
	logic        wbEn;
	data_addr_s  wbA;
	logic [7:0]  wbV;
	logic [1:0]  bank;
	logic [15:0] pcN;
	logic [10:0] absTgt;
	data_addr_s  bitByte;
	logic [31:0] rd;

	data_ram u_ram (
		.clk   (clk),
		.req   (mreq),
		.rdata (memRd)
	);

	arith_unit u_alu (
		.a       (aluA),
		.b       (operand),
		.carryIn (q.statusWord[FLAG_CARRY]),
		.op      (aluOp),
		.y       (aluY)
	);

	assign pready = q.pready;
	assign prdata = q.prdata;
	assign pslverr = q.pslverr;
	assign acc = q.acc;
	assign statusWord = q.statusWord;

	// Decode of the word being started, or of the one in flight
	always_comb
	begin
		idle = q.st == ST_IDLE;
		cur = idle ? pwdata[23:0] : q.instr;
		opc = cur[7:0];
		op1 = cur[15:8];
		lo = opc[3:0];
		hi = opc[7:4];
		bank = q.statusWord[BANK_SEL_LSB +: 2];
		isInc = hi == GRP_INC;
		isArith = (isInc || hi == GRP_ADD || hi == GRP_ADD_CARRY || hi == GRP_SUB_BORROW) && lo >= LO_IMM;
		isBit = opc == OP_SETB || opc == OP_CLRB;
		unique case (hi)
			GRP_ADD: aluOp = ALU_ADD;
			GRP_ADD_CARRY: aluOp = ALU_ADD_CARRY;
			GRP_SUB_BORROW: aluOp = ALU_SUB_BORROW;
			default: aluOp = ALU_INC;
		endcase
		if (op1[7])
			bitByte = '{sfr: 1'b1, addr: op1 & BIT_BYTE_MASK};
		else
			bitByte = '{sfr: 1'b0, addr: BIT_RAM_BASE + {3'h0, op1[7:3]}};
		pcN = q.pc + {14'h0, (opc == OP_LONG_JUMP || opc == OP_LONG_CALL) ? LEN3 : LEN2};
		absTgt = {opc[7:5], op1};
	end

	// Direct reads of core registers come from flip-flops, the rest from memory
	always_comb
	begin
		opndVal = memRd;
		if (q.opAddr.sfr)
		begin
			case (q.opAddr.addr)
				SFR_ACC: opndVal = q.acc;
				SFR_STWORD: opndVal = q.statusWord;
				SFR_SP: opndVal = q.sp;
				SFR_DPL: opndVal = q.dptr[7:0];
				SFR_DPH: opndVal = q.dptr[15:8];
				default: opndVal = memRd;
			endcase
		end
		operand = start ? (isInc ? q.acc : op1) : opndVal;
		aluA = isInc ? operand : q.acc;
	end

	always_comb
	begin
		rd = '0;
		unique case (paddr)
			REG_INSTR: rd[23:0] = q.instr;
			REG_ACC: rd[7:0] = q.acc;
			REG_STWORD: rd[7:0] = q.statusWord;
			REG_PC: rd[15:0] = q.pc;
			REG_DADDR: rd[8:0] = q.dAddr;
			REG_DATA: rd[7:0] = memRd;
			REG_SP: rd[7:0] = q.sp;
			REG_DPTR: rd[15:0] = q.dptr;
			default:
			begin
				rd[STAT_ILLEGAL] = q.illegal;
				rd[STAT_LEN_LSB +: 2] = q.len;
			end
		endcase
	end

	always_comb
	begin
		d = q;
		d.pready = 1'b0;
		d.pslverr = 1'b0;
		mreq = '0;
		mreq.a = q.dAddr;
		wbEn = 1'b0;
		wbA = q.opAddr;
		wbV = aluY.res;
		// APB waits while an instruction runs, and for data read to settle
		respond = psel && penable && !q.pready && idle && (pwrite || paddr != REG_DATA || q.memOnData);
		start = respond && pwrite && paddr == REG_INSTR;
		d.memOnData = idle && !(respond && pwrite && (paddr == REG_DADDR || paddr == REG_INSTR));
		if (respond)
		begin
			d.pready = 1'b1;
			if (!pwrite)
				d.prdata = rd;
			case (paddr)
				REG_INSTR, REG_DATA, REG_ACC, REG_STWORD, REG_PC, REG_DADDR, REG_SP, REG_DPTR, REG_STATUS: ;
				default: d.pslverr = 1'b1;
			endcase
			if (pwrite)
			begin
				case (paddr)
					REG_ACC: d.acc = pwdata[7:0];
					REG_STWORD: d.statusWord = pwdata[7:0];
					REG_PC: d.pc = pwdata[15:0];
					REG_SP: d.sp = pwdata[7:0];
					REG_DPTR: d.dptr = pwdata[15:0];
					REG_DADDR: d.dAddr = pwdata[8:0];
					REG_DATA:
					begin
						mreq.we = 1'b1;
						mreq.wd = pwdata[7:0];
					end
					default: ;
				endcase
			end
		end
		if (start)
		begin
			d.instr = cur;
			d.illegal = 1'b0;
			if (isArith)
			begin
				if (lo == LO_IMM)
				begin
					d.len = isInc ? LEN1 : LEN2;
					if (!isInc)
					begin
						d.statusWord[FLAG_CARRY] = aluY.carry;
						d.statusWord[FLAG_AUX] = aluY.auxCarry;
						d.statusWord[FLAG_OVER] = aluY.overflow;
					end
					d.acc = aluY.res;
				end
				else if (lo == LO_DIR)
				begin
					d.len = LEN2;
					d.opAddr = '{sfr: op1[7], addr: op1};
					d.st = ST_OPND;
				end
				else if (lo[3:1] == LO_IND)
				begin
					d.len = LEN1;
					d.opAddr = '{sfr: 1'b0, addr: {3'h0, bank, 2'h0, lo[0]}};
					d.st = ST_PTR;
				end
				else
				begin
					d.len = LEN1;
					d.opAddr = '{sfr: 1'b0, addr: {3'h0, bank, lo[2:0]}};
					d.st = ST_OPND;
				end
				mreq.a = d.opAddr;
				d.pc = q.pc + {14'h0, d.len};
			end
			else if (opc == OP_SHORT_JUMP)
			begin
				d.len = LEN2;
				d.pc = pcN + {{8{op1[7]}}, op1};
			end
			else if (opc[4:0] == OP_ABS_JUMP || opc[4:0] == OP_ABS_CALL)
			begin
				d.len = LEN2;
				d.pc = {pcN[15:11], absTgt};
				d.ret = pcN;
				d.st = opc[4:0] == OP_ABS_CALL ? ST_PUSH_LO : ST_IDLE;
			end
			else if (opc == OP_LONG_JUMP || opc == OP_LONG_CALL)
			begin
				d.len = LEN3;
				d.pc = {op1, cur[23:16]};
				d.ret = pcN;
				d.st = opc == OP_LONG_CALL ? ST_PUSH_LO : ST_IDLE;
			end
			else if (opc == OP_MOVDP)
			begin
				d.len = LEN3;
				d.dptr = {op1, cur[23:16]};
				d.pc = pcN;
			end
			else if (isBit)
			begin
				d.len = LEN2;
				d.opAddr = bitByte;
				mreq.a = bitByte;
				d.pc = pcN;
				d.st = ST_OPND;
			end
			else
				d.illegal = 1'b1;
		end
		unique case (q.st)
			ST_IDLE: ;
			ST_PTR:
			begin
				d.opAddr = '{sfr: 1'b0, addr: memRd};
				mreq.a = d.opAddr;
				d.st = ST_OPND;
			end
			ST_OPND:
			begin
				d.st = ST_IDLE;
				if (isBit)
				begin
					wbEn = 1'b1;
					wbV = opndVal;
					wbV[op1[2:0]] = opc == OP_SETB;
				end
				else if (isInc)
					wbEn = 1'b1;
				else
				begin
					d.acc = aluY.res;
					d.statusWord[FLAG_CARRY] = aluY.carry;
					d.statusWord[FLAG_AUX] = aluY.auxCarry;
					d.statusWord[FLAG_OVER] = aluY.overflow;
				end
			end
			ST_PUSH_LO, ST_PUSH_HI:
			begin
				d.sp = q.sp + 8'h01;
				mreq.we = 1'b1;
				mreq.a = '{sfr: 1'b0, addr: d.sp};
				mreq.wd = q.st == ST_PUSH_LO ? q.ret[7:0] : q.ret[15:8];
				d.st = q.st == ST_PUSH_LO ? ST_PUSH_HI : ST_IDLE;
			end
		endcase
		if (wbEn)
		begin
			if (wbA.sfr && wbA.addr == SFR_ACC)
				d.acc = wbV;
			else if (wbA.sfr && wbA.addr == SFR_STWORD)
				d.statusWord = wbV;
			else if (wbA.sfr && wbA.addr == SFR_SP)
				d.sp = wbV;
			else if (wbA.sfr && wbA.addr == SFR_DPL)
				d.dptr[7:0] = wbV;
			else if (wbA.sfr && wbA.addr == SFR_DPH)
				d.dptr[15:8] = wbV;
			else
			begin
				mreq.we = 1'b1;
				mreq.a = wbA;
				mreq.wd = wbV;
			end
		end
		d.statusWord[FLAG_PARITY] = ^d.acc;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			q <= '0;
			q.sp <= SP_RESET;
		end
		else
			q <= d;
	end

	// Helpers read only by the checks below
	logic [8:0]  immSum;
	logic [4:0]  pcPage;
	logic [7:0]  dirAddr;
	logic [15:0] opWord;
	logic [2:0]  flagBits;
	assign immSum = {1'b0, q.acc} + {1'b0, pwdata[15:8]};
	assign pcPage = pcN[15:11];
	assign dirAddr = pwdata[15:8];
	assign opWord = {pwdata[15:8], pwdata[23:16]};
	assign flagBits = {q.statusWord[FLAG_CARRY], q.statusWord[FLAG_AUX], q.statusWord[FLAG_OVER]};

	a_upper_indirect: assert property (@(posedge clk) disable iff (!arst_n)
		q.st == ST_PTR |=> q.st == ST_OPND && !q.opAddr.sfr) else $error("Indirect operand left RAM space");
	a_direct_space: assert property (@(posedge clk) disable iff (!arst_n)
		start && isArith && lo == LO_DIR |=> q.opAddr.sfr == $past(dirAddr[7]) && q.opAddr.addr == $past(dirAddr))
		else $error("Direct operand space wrong");
	a_stack_push: assert property (@(posedge clk) disable iff (!arst_n)
		start && opc == OP_LONG_CALL |-> ##1 mreq.we && !mreq.a.sfr ##1 mreq.we ##1 q.sp == $past(q.sp, 3) + 8'h02)
		else $error("Call push sequence wrong");
	a_bit_sfr: assert property (@(posedge clk) disable iff (!arst_n)
		start && isBit && dirAddr[7] |=> q.opAddr == {1'b1, $past(dirAddr) & BIT_BYTE_MASK})
		else $error("Control register bit mapping wrong");
	a_bit_ram: assert property (@(posedge clk) disable iff (!arst_n)
		start && isBit && !dirAddr[7] |=> !q.opAddr.sfr && q.opAddr.addr[7:4] == BIT_RAM_BASE[7:4])
		else $error("RAM bit mapping wrong");
	a_bank_select: assert property (@(posedge clk) disable iff (!arst_n)
		start && isArith && lo[LO_REG_BIT] |=> q.opAddr.addr[4:3] == $past(bank) && q.st == ST_OPND)
		else $error("Bank register outside selected bank");
	a_rel_target: assert property (@(posedge clk) disable iff (!arst_n)
		start && opc == OP_SHORT_JUMP |=> q.pc == $past(q.pc) + 16'h0002 + {{8{$past(dirAddr[7])}}, $past(dirAddr)})
		else $error("Relative target wrong");
	a_abs_page: assert property (@(posedge clk) disable iff (!arst_n)
		start && opc[4:0] == OP_ABS_JUMP |=> q.pc[15:11] == $past(pcPage)) else $error("Absolute jump left page");
	a_long_target: assert property (@(posedge clk) disable iff (!arst_n)
		start && opc == OP_LONG_JUMP |=> q.pc == $past(opWord)) else $error("Long jump target wrong");
	a_add_imm: assert property (@(posedge clk) disable iff (!arst_n)
		start && opc == {GRP_ADD, LO_IMM} |=> {q.statusWord[FLAG_CARRY], q.acc} == $past(immSum)
		&& q.pc == $past(q.pc) + 16'h0002)
		else $error("Immediate add result wrong");
	a_inc_flags: assert property (@(posedge clk) disable iff (!arst_n)
		q.st == ST_OPND && isInc |=> flagBits == $past(flagBits) || $past(q.opAddr) == {1'b1, SFR_STWORD})
		else $error("Increment changed flags");
endmodule
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench for the data-space and arithmetic decoder.
// Drives the APB port itself; expectations come from the opcode and flag rules.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic        clk = 1'b0;
	logic        arstN = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic [7:0]  acc;
	logic [7:0]  statusWord;
	int          numErrors = 0;
	int          numChecks = 0;
	int          cycles = 0;
	logic [31:0] rdData;
	logic        rdErr;

	cpu_data_space_arith_decode i_cpu_data_space_arith_decode (
		.clk     (clk),
		.arst_n  (arstN),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.pready  (pready),
		.prdata  (prdata),
		.pslverr (pslverr),
		.acc     (acc),
		.statusWord (statusWord)
	);

	always #12.5 clk = ~clk;

	task automatic tallyAndFinish();
		$display("checks %0d errors %0d", numChecks, numErrors);
		if (numErrors == 0 && numChecks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Cuts a hung run short
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			numErrors++;
			tallyAndFinish();
		end
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		numChecks++;
		if (got !== exp)
		begin
			numErrors++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One APB transfer; waits for pready, the run's cycle ceiling ends a hang
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rdData = prdata;
		rdErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(name, exp, rdData);
	endtask

	task automatic ex(input logic [23:0] ins);
		wr(data_space_pkg::REG_INSTR, {8'h00, ins});
	endtask

	task automatic setMem(input logic [8:0] a, input logic [7:0] v);
		wr(data_space_pkg::REG_DADDR, {23'h0, a});
		wr(data_space_pkg::REG_DATA, {24'h0, v});
	endtask

	task automatic memChk(input string name, input logic [8:0] a, input logic [7:0] v);
		wr(data_space_pkg::REG_DADDR, {23'h0, a});
		rdc(name, data_space_pkg::REG_DATA, {24'h0, v});
	endtask

	// Loads accumulator and status word, runs one instruction, checks both
	task automatic alu(input logic [7:0] a0, input logic [7:0] s0, input logic [23:0] ins,
		input logic [7:0] a1, input logic [7:0] s1);
		wr(data_space_pkg::REG_ACC, {24'h0, a0});
		wr(data_space_pkg::REG_STWORD, {24'h0, s0});
		ex(ins);
		rdc("acc", data_space_pkg::REG_ACC, {24'h0, a1});
		rdc("status word", data_space_pkg::REG_STWORD, {24'h0, s1});
	endtask

	initial
	begin
		repeat (2) @(posedge clk);
		arstN <= 1'b1;
		rdc("acc", data_space_pkg::REG_ACC, 32'h0);
		rdc("sp", data_space_pkg::REG_SP, 32'h7);
		rdc("pc", data_space_pkg::REG_PC, 32'h0);
		rdc("dptr", data_space_pkg::REG_DPTR, 32'h0);
		// Immediate forms with carry, half carry, overflow and borrow
		alu(8'h7f, 8'h00, 24'h000124, 8'h80, 8'h45);
		chk("acc port", 32'h80, {24'h0, acc});
		chk("status port", 32'h45, {24'h0, statusWord});
		rdc("length", data_space_pkg::REG_STATUS, 32'h8);
		rdc("pc", data_space_pkg::REG_PC, 32'h2);
		alu(8'hff, 8'h80, 24'h000034, 8'h00, 8'hc0);
		alu(8'h00, 8'h00, 24'h000194, 8'hff, 8'hc0);
		alu(8'h80, 8'h80, 24'h000094, 8'h7f, 8'h45);
		// Bank registers follow the bank select field
		setMem(9'h008, 8'h11);
		setMem(9'h000, 8'h55);
		setMem(9'h01f, 8'h20);
		alu(8'h01, 8'h08, 24'h000028, 8'h12, 8'h08);
		alu(8'h00, 8'h18, 24'h00003f, 8'h20, 8'h19);
		alu(8'h21, 8'h18, 24'h00009f, 8'h01, 8'h19);
		// Direct high addresses hit control space, indirect hits upper RAM
		setMem(9'h090, 8'h33);
		setMem(9'h190, 8'h22);
		setMem(9'h040, 8'h05);
		alu(8'h00, 8'h00, 24'h009025, 8'h22, 8'h00);
		alu(8'h22, 8'h00, 24'h004035, 8'h27, 8'h00);
		rdc("length", data_space_pkg::REG_STATUS, 32'h8);
		alu(8'h30, 8'h00, 24'h004095, 8'h2b, 8'h40);
		setMem(9'h001, 8'h90);
		setMem(9'h000, 8'h40);
		alu(8'h00, 8'h00, 24'h000027, 8'h33, 8'h00);
		rdc("length", data_space_pkg::REG_STATUS, 32'h4);
		alu(8'h33, 8'h00, 24'h000026, 8'h38, 8'h01);
		alu(8'h38, 8'h00, 24'h000037, 8'h6b, 8'h01);
		alu(8'h38, 8'h00, 24'h000097, 8'h05, 8'h00);
		// Increment leaves the flags alone
		alu(8'hff, 8'h80, 24'h000004, 8'h00, 8'h80);
		setMem(9'h002, 8'hfe);
		ex(24'h00000a);
		memChk("inc reg", 9'h002, 8'hff);
		setMem(9'h030, 8'h7f);
		ex(24'h003005);
		memChk("inc direct", 9'h030, 8'h80);
		rdc("length", data_space_pkg::REG_STATUS, 32'h8);
		rdc("status word", data_space_pkg::REG_STWORD, 32'h80);
		// Bit addressing in lower RAM and control registers
		setMem(9'h020, 8'h00);
		setMem(9'h180, 8'h00);
		setMem(9'h1f8, 8'hff);
		ex(24'h0003d2);
		memChk("bit ram", 9'h020, 8'h08);
		ex(24'h0085d2);
		memChk("bit ctrl", 9'h180, 8'h20);
		ex(24'h00ffc2);
		memChk("bit ctrl", 9'h1f8, 8'h7f);
		// Branch targets
		wr(data_space_pkg::REG_PC, 32'h1000);
		ex(24'h00fe80);
		rdc("pc", data_space_pkg::REG_PC, 32'h1000);
		ex(24'h007f80);
		rdc("pc", data_space_pkg::REG_PC, 32'h1081);
		wr(data_space_pkg::REG_PC, 32'h17fe);
		ex(24'h003421);
		rdc("pc", data_space_pkg::REG_PC, 32'h1934);
		ex(24'h341202);
		rdc("pc", data_space_pkg::REG_PC, 32'h1234);
		ex(24'hcdab90);
		rdc("dptr", data_space_pkg::REG_DPTR, 32'habcd);
		// Calls push the return address through indirect RAM access
		wr(data_space_pkg::REG_SP, 32'h7f);
		wr(data_space_pkg::REG_PC, 32'h07fe);
		ex(24'h001011);
		rdc("pc", data_space_pkg::REG_PC, 32'h0810);
		rdc("sp", data_space_pkg::REG_SP, 32'h81);
		memChk("push lo", 9'h080, 8'h00);
		memChk("push hi", 9'h081, 8'h08);
		ex(24'h785612);
		rdc("pc", data_space_pkg::REG_PC, 32'h5678);
		memChk("push lo", 9'h082, 8'h13);
		memChk("push hi", 9'h083, 8'h08);
		// Unknown opcode and unmapped register
		wr(data_space_pkg::REG_ACC, 32'h5a);
		ex(24'h0000a5);
		apb(1'b0, data_space_pkg::REG_STATUS, 32'h0);
		chk("illegal", 32'h1, {31'h0, rdData[0]});
		rdc("acc", data_space_pkg::REG_ACC, 32'h5a);
		apb(1'b1, 8'h40, 32'h0);
		chk("slverr", 32'h1, {31'h0, rdErr});
		apb(1'b0, 8'h44, 32'h0);
		chk("slverr", 32'h1, {31'h0, rdErr});
		tallyAndFinish();
	end
endmodule
`default_nettype wire
